// *** src/bir_irq_router.sv ***
// Board interrupt routing: source selection, master controller, cascade address
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - Eight request inputs, each maskable, priority resolved, with its own vector.
// R2 - Each input takes one selectable source among fourteen board sources.
// R3 - Vectors stay distinct; a duplicating configuration write is refused.
// R4 - Desktop preset maps inputs 0..7 to vectors 08h..0Fh with fixed sources.
// R5 - Vector and source of each input remain writable after reset.
// R6 - Cascaded input acknowledge drives the slave identifier on A8..A10.
// R7 - Backplane slave raises request, sees its identifier, answers the acknowledge.
// R8 - Four front-plane lines feed inputs 3 through 6.
// R9 - Calendar tick period selectable: 1/64 s, 1 s, 1 min, 1 h.
// R10 - Acknowledge returns highest eligible vector, holds input in service until end.
module bir_irq_router import bir_pkg::*; #(
	parameter bit DESKTOP_PRESET = 1'b1,
	parameter int RTC_CYC = RTC_BASE_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Request pins, asynchronous
	input wire logic [3:0] front_request_n,
	input wire logic [1:0] serial_irq,
	input wire logic [2:0] timer_out,
	input wire logic expansion_irq,
	input wire logic backplane_request_primary_n,
	input wire logic backplane_request_second_n,
	input wire logic backplane_request_third_n,
	// Configuration, same clock
	input wire logic [1:0] rtc_period_sel,
	input wire logic cfg_wr,
	input wire logic [2:0] cfg_sel,
	input wire logic [3:0] cfg_src,
	input wire logic [7:0] cfg_vec,
	input wire logic mask_wr,
	input wire logic [7:0] mask_val,
	input wire logic cascade_wr,
	input wire logic [7:0] cascade_val,
	input wire logic eoi,
	// Processor side
	input wire logic inta,
	output logic int_req,
	output logic [7:0] ack_vector,
	output logic ack_vector_oe,
	output logic [7:0] in_service,
	output logic cfg_refused,
	// Backplane cascade address A8..A10
	output logic [2:0] cas_addr,
	output logic cas_addr_oe
);
	localparam logic [7:0][7:0] VEC_INIT = DESKTOP_PRESET ? DESKTOP_VEC : GENERIC_VEC;
	localparam logic [7:0][3:0] ROUTE_INIT = DESKTOP_PRESET ? DESKTOP_ROUTE : GENERIC_ROUTE;

	logic [NUM_EXT-1:0] ext_raw;
	logic [NUM_EXT-1:0] sync1_r;
	logic [NUM_EXT-1:0] sync2_r;
	logic [NUM_EXT-1:0] sync3_r;
	logic [NUM_EXT-1:0] filt_r;
	logic rtc_tick;
	logic [NUM_SRC-1:0] src_lvl;
	logic [NUM_SRC-1:0] src_prev_r;
	logic [NUM_SRC-1:0] src_rise;
	logic [7:0][7:0] vec_tab_r;
	logic [7:0][3:0] route_r;
	logic [7:0] mask_r;
	logic [7:0] cascade_r;
	logic [7:0] pending_r;
	logic [7:0] src_set;
	logic [7:0] elig;
	logic [3:0] isr_pick;
	logic [3:0] elig_pick;
	logic inta_d_r;
	logic ack_take;
	logic [2:0] ack_idx;
	logic cfg_dup;
	bir_state_e state_r;

	// Lowest set index wins; bit 3 flags that one was found
	function automatic logic [3:0] prio_pick(input logic [7:0] bits);
		logic [3:0] res;
		res = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (bits[i]) res = {1'b1, 3'(i)};
		end
		return res;
	endfunction : prio_pick

	// True when another input already owns this vector
	function automatic logic vec_taken(input logic [7:0][7:0] tab, input logic [7:0] vec,
		input logic [2:0] sel);
		logic hit;
		hit = 1'b0;
		for (int j = 0; j < NUM_IN; j++) begin
			if (3'(j) != sel && tab[j] == vec) hit = 1'b1;
		end
		return hit;
	endfunction : vec_taken

	// Pins are mostly active low behind pull-ups
	assign ext_raw = {~backplane_request_third_n, ~backplane_request_second_n,
		~backplane_request_primary_n, expansion_irq, timer_out, serial_irq, ~front_request_n};

	// Three-stage synchroniser; level changes once stages two and three agree
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
		end else begin
			sync1_r <= ext_raw;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// Agreement filter, one bit per line
	for (genvar g = 0; g < NUM_EXT; g++) begin : g_filt
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				filt_r[g] <= 1'b0;
			end else if (sync2_r[g] == sync3_r[g]) begin
				filt_r[g] <= sync3_r[g];
			end
		end
	end

	bir_rtc_tick #(.BASE_CYC(RTC_CYC)) u_rtc_tick (
		.clk(clk),
		.reset(reset),
		.period_sel(rtc_period_sel),
		.tick(rtc_tick)
	);

	// Calendar tick joins the source set at its own code
	assign src_lvl = {filt_r[12:10], rtc_tick, filt_r[9:0]}; // R9
	assign src_rise = src_lvl & ~src_prev_r;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			src_prev_r <= '0;
		end else begin
			src_prev_r <= src_lvl;
		end
	end

	// Routing: each input watches the edge of its chosen source
	for (genvar g = 0; g < NUM_IN; g++) begin : g_route
		assign src_set[g] = (route_r[g] < 4'(NUM_SRC)) && src_rise[route_r[g]]; // R2 R8
	end

	// Eligible: pending, unmasked, above every input in service
	always_comb begin
		isr_pick = prio_pick(in_service);
		elig = pending_r & ~mask_r; // R1
		if (isr_pick[3]) elig = elig & 8'((9'h001 << isr_pick[2:0]) - 9'h001); // R10
		elig_pick = prio_pick(elig);
	end

	assign ack_take = inta && !inta_d_r && (state_r == ST_IDLE);
	assign ack_idx = elig_pick[3] ? elig_pick[2:0] : SPURIOUS_IN;
	assign cfg_dup = vec_taken(vec_tab_r, cfg_vec, cfg_sel);

	// Vector and routing tables; duplicates refused so vectors stay unique
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			vec_tab_r <= VEC_INIT; // R4
			route_r <= ROUTE_INIT; // R4 R8
			cfg_refused <= 1'b0;
		end else begin
			cfg_refused <= cfg_wr && cfg_dup; // R3
			if (cfg_wr && !cfg_dup) begin
				vec_tab_r[cfg_sel] <= cfg_vec; // R5
				route_r[cfg_sel] <= cfg_src; // R5 R2
			end
		end
	end

	// Mask and cascade selection
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mask_r <= MASK_RESET;
			cascade_r <= CASCADE_RESET;
		end else begin
			if (mask_wr) mask_r <= mask_val; // R1
			if (cascade_wr) cascade_r <= cascade_val;
		end
	end

	// Pending and in-service; a new event beats the clear in the same cycle
	for (genvar g = 0; g < NUM_IN; g++) begin : g_state
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				pending_r[g] <= 1'b0;
				in_service[g] <= 1'b0;
			end else begin
				pending_r[g] <= src_set[g] ||
					(pending_r[g] && !(ack_take && elig_pick[3] && ack_idx == 3'(g)));
				in_service[g] <= (ack_take && elig_pick[3] && ack_idx == 3'(g)) || // R10
					(in_service[g] && !(eoi && isr_pick[3] && isr_pick[2:0] == 3'(g)));
			end
		end
	end

	// Request line to the processor, low while an acknowledge runs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			int_req <= 1'b0;
			inta_d_r <= 1'b0;
		end else begin
			int_req <= (|elig) && (state_r == ST_IDLE) && !ack_take; // R1
			inta_d_r <= inta;
		end
	end

	// Acknowledge sequencer; slave-served inputs leave the vector to the slave
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
			ack_vector <= 8'h00;
			ack_vector_oe <= 1'b0;
			cas_addr <= 3'h0;
			cas_addr_oe <= 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (ack_take) begin
						state_r <= ST_ACK;
						ack_vector <= vec_tab_r[ack_idx]; // R10 R3
						ack_vector_oe <= !cascade_r[ack_idx]; // R10
						cas_addr <= ack_idx; // R6
						cas_addr_oe <= cascade_r[ack_idx]; // R6 R7
					end
				end
				ST_ACK: begin
					if (!inta) begin
						state_r <= ST_IDLE;
						ack_vector_oe <= 1'b0;
						cas_addr_oe <= 1'b0; // R6
					end
				end
				default: begin
					state_r <= ST_IDLE;
					ack_vector_oe <= 1'b0;
					cas_addr_oe <= 1'b0;
				end
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_take_direct;
		ack_take && elig_pick[3] && !cascade_r[elig_pick[2:0]];
	endsequence
	sequence s_take_cascade;
		ack_take && elig_pick[3] && cascade_r[elig_pick[2:0]];
	endsequence

	chk_ack_vector_out: assert property (s_take_direct |=> // R10
		ack_vector_oe && ack_vector == $past(vec_tab_r[elig_pick[2:0]]))
		else $error("acknowledge vector wrong");
	chk_ack_in_service: assert property (s_take_direct |=> // R10
		in_service[$past(elig_pick[2:0])] && !pending_r[$past(elig_pick[2:0])] ||
		$past(src_set[elig_pick[2:0]]))
		else $error("acknowledged input not in service");
	chk_masked_no_req: assert property ((pending_r & ~mask_r) == 8'h00 |=> !int_req) // R1
		else $error("request raised with nothing unmasked");
	chk_route_write: assert property (cfg_wr && !cfg_dup |=> // R2
		route_r[$past(cfg_sel)] == $past(cfg_src))
		else $error("source routing not updated");
	chk_vec_reprog: assert property (cfg_wr && !cfg_dup |=> // R5
		vec_tab_r[$past(cfg_sel)] == $past(cfg_vec))
		else $error("vector not updated");
	chk_vec_unique: assert property (cfg_wr && cfg_dup |=> // R3
		vec_tab_r == $past(vec_tab_r) && cfg_refused)
		else $error("duplicate vector accepted");
	chk_desktop_map: assert property ($fell(reset) |-> !DESKTOP_PRESET || // R4
		(vec_tab_r[0] == 8'h08 && vec_tab_r[7] == 8'h0F && route_r[2] == SRC_BP_PRI))
		else $error("desktop preset wrong");
	chk_cascade_drive: assert property (s_take_cascade |=> // R6
		cas_addr_oe && !ack_vector_oe && cas_addr == $past(elig_pick[2:0]))
		else $error("cascade address not driven");
	chk_cascade_release: assert property (state_r == ST_ACK && !inta |=> !cas_addr_oe) // R6
		else $error("cascade address not released");
	chk_front_feed: assert property (route_r[3] == SRC_FRONT0 && src_rise[SRC_FRONT0] // R8
		|=> pending_r[3])
		else $error("front line did not set input 3");
	chk_eoi_clear: assert property (eoi && isr_pick[3] && !ack_take |=> // R10
		!in_service[$past(isr_pick[2:0])])
		else $error("end of service ignored");
endmodule : bir_irq_router
`default_nettype wire

// *** src/bir_pkg.sv ***
// Shared constants and types for the board interrupt routing block
package bir_pkg;
	// Controller shape
	localparam int NUM_IN = 8;
	localparam int NUM_SRC = 14;
	localparam int NUM_EXT = 13;

	typedef logic [3:0] bir_src_t;
	typedef logic [7:0] bir_vec_t;

	// Source selection codes
	localparam bir_src_t SRC_FRONT0 = 4'h0;
	localparam bir_src_t SRC_FRONT1 = 4'h1;
	localparam bir_src_t SRC_FRONT2 = 4'h2;
	localparam bir_src_t SRC_FRONT3 = 4'h3;
	localparam bir_src_t SRC_SER0 = 4'h4;
	localparam bir_src_t SRC_SER1 = 4'h5;
	localparam bir_src_t SRC_TMR0 = 4'h6;
	localparam bir_src_t SRC_TMR1 = 4'h7;
	localparam bir_src_t SRC_TMR2 = 4'h8;
	localparam bir_src_t SRC_EXP = 4'h9;
	localparam bir_src_t SRC_RTC = 4'hA;
	localparam bir_src_t SRC_BP_PRI = 4'hB;
	localparam bir_src_t SRC_BP_SEC = 4'hC;
	localparam bir_src_t SRC_BP_THI = 4'hD;
	localparam bir_src_t SRC_NONE = 4'hF;

	// Reset tables, entry 0 in the low bits
	localparam logic [7:0][7:0] DESKTOP_VEC = {8'h0F, 8'h0E, 8'h0D, 8'h0C,
		8'h0B, 8'h0A, 8'h09, 8'h08};
	localparam logic [7:0][3:0] DESKTOP_ROUTE = {SRC_NONE, SRC_FRONT3, SRC_NONE,
		SRC_BP_THI, SRC_BP_SEC, SRC_BP_PRI, SRC_EXP, SRC_TMR0};
	localparam logic [7:0][7:0] GENERIC_VEC = {8'h27, 8'h26, 8'h25, 8'h24,
		8'h23, 8'h22, 8'h21, 8'h20};
	localparam logic [7:0][3:0] GENERIC_ROUTE = {SRC_BP_PRI, SRC_FRONT3, SRC_FRONT2,
		SRC_FRONT1, SRC_FRONT0, SRC_SER1, SRC_SER0, SRC_RTC};
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] CASCADE_RESET = 8'h00;
	localparam logic [2:0] SPURIOUS_IN = 3'h7;

	// Periodic tick timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int RTC_BASE_NS = 15625000;
	localparam int RTC_BASE_CYC = (RTC_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] TICKS_PER_SEC = 7'h40;
	localparam logic [6:0] SEC_PER_MIN = 7'h3C;
	localparam logic [6:0] MIN_PER_HOUR = 7'h3C;
	localparam logic [1:0] PER_64TH = 2'h0;
	localparam logic [1:0] PER_SEC = 2'h1;
	localparam logic [1:0] PER_MIN = 2'h2;
	localparam logic [1:0] PER_HOUR = 2'h3;

	// Acknowledge sequencer
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACK = 2'b01
	} bir_state_e;
endpackage : bir_pkg

// *** src/bir_rtc_tick.sv ***
// Periodic calendar tick with selectable period
`timescale 1ns/1ps
`default_nettype none
module bir_rtc_tick import bir_pkg::*; #(
	parameter int BASE_CYC = RTC_BASE_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Period choice
	input wire logic [1:0] period_sel,
	// Tick out
	output logic tick
);
	logic [31:0] base_cnt_r;
	logic [6:0] sub_cnt_r;
	logic [6:0] sec_cnt_r;
	logic [6:0] min_cnt_r;
	logic base_hit;
	logic sec_hit;
	logic min_hit;
	logic hour_hit;

	// Cascaded dividers keep the three counters above the 32-bit base divider at 7 bits
	assign base_hit = (base_cnt_r == 32'(BASE_CYC - 1));
	assign sec_hit = base_hit && (sub_cnt_r == TICKS_PER_SEC - 7'h01);
	assign min_hit = sec_hit && (sec_cnt_r == SEC_PER_MIN - 7'h01);
	assign hour_hit = min_hit && (min_cnt_r == MIN_PER_HOUR - 7'h01);

	// Base divider for 1/64 s
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			base_cnt_r <= 32'h00000000;
		end else begin
			base_cnt_r <= base_hit ? 32'h00000000 : base_cnt_r + 32'h00000001;
		end
	end

	// Second, minute and hour counters
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sub_cnt_r <= 7'h00;
			sec_cnt_r <= 7'h00;
			min_cnt_r <= 7'h00;
		end else begin
			if (base_hit) sub_cnt_r <= sec_hit ? 7'h00 : sub_cnt_r + 7'h01;
			if (sec_hit) sec_cnt_r <= min_hit ? 7'h00 : sec_cnt_r + 7'h01;
			if (min_hit) min_cnt_r <= hour_hit ? 7'h00 : min_cnt_r + 7'h01;
		end
	end

	// One-cycle tick at the chosen period
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tick <= 1'b0;
		end else begin
			case (period_sel)
				PER_64TH: tick <= base_hit; // R9
				PER_SEC: tick <= sec_hit; // R9
				PER_MIN: tick <= min_hit; // R9
				PER_HOUR: tick <= hour_hit; // R9
				default: tick <= 1'b0;
			endcase
		end
	end

	chk_tick_period: assert property (@(posedge clk) disable iff (reset) // R9
		tick |-> $past(base_hit) && ($past(period_sel) == PER_64TH || $past(sec_hit)))
		else $error("tick off its selected period");
endmodule : bir_rtc_tick
`default_nettype wire

// *** sim/bir_slave_card.sv ***
// Backplane card model holding a slave controller
`timescale 1ns/1ps
`default_nettype none
module bir_slave_card import bir_pkg::*; #(
	parameter logic [2:0] CARD_ID = 3'h2,
	parameter bir_vec_t CARD_VEC = 8'h60
) (
	// Request from the card's own peripheral
	input wire logic raise,
	// Acknowledge as seen on the backplane
	input wire logic inta,
	input wire logic [2:0] cas_addr,
	input wire logic cas_addr_oe,
	// Backplane request and vector answer
	output logic request_n,
	output logic resp_oe,
	output logic [7:0] resp_vec
);
	// Request line low while the card wants service
	assign request_n = ~raise;
	// Answers only when its own identifier sits on A8..A10
	assign resp_oe = inta & cas_addr_oe & (cas_addr == CARD_ID);
	// Released bus shows the inverse, so a stale vector cannot pass
	assign resp_vec = resp_oe ? CARD_VEC : ~CARD_VEC;
endmodule : bir_slave_card
`default_nettype wire

// *** sim/board_interrupt_routing_bench.sv ***
// Self-checking bench for the board interrupt routing block
`timescale 1ns/1ps
`default_nettype none
module board_interrupt_routing_bench import bir_pkg::*;;
	// Clock, reset and stimulus
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] front_n = 4'hF;
	logic [1:0] ser = 2'h0;
	logic [2:0] tmr = 3'h0;
	logic exp_irq = 1'b0;
	logic bp2_n = 1'b1;
	logic bp3_n = 1'b1;
	logic [1:0] period = PER_64TH;
	logic cfg_wr = 1'b0;
	logic [2:0] cfg_sel = 3'h0;
	bir_src_t cfg_src = SRC_NONE;
	bir_vec_t cfg_vec = 8'h00;
	logic mask_wr = 1'b0;
	logic [7:0] mask_val = 8'h00;
	logic casc_wr = 1'b0;
	logic [7:0] casc_val = 8'h00;
	logic eoi = 1'b0;
	logic inta = 1'b0;
	logic card_raise = 1'b0;
	// Observed signals
	wire logic bp1_n, int_req, vec_oe, refused, cas_oe, card_oe;
	wire logic [7:0] vec, in_svc, card_vec;
	wire logic [2:0] cas;
	int cyc = 0;
	int mismatches = 0;
	int samples_checked = 0;

	// Short tick base keeps the second period at 256 cycles
	bir_irq_router #(.DESKTOP_PRESET(1'b1), .RTC_CYC(4)) DUT (.clk(clk), .reset(reset),
		.front_request_n(front_n), .serial_irq(ser), .timer_out(tmr), .expansion_irq(exp_irq),
		.backplane_request_primary_n(bp1_n), .backplane_request_second_n(bp2_n),
		.backplane_request_third_n(bp3_n), .rtc_period_sel(period), .cfg_wr(cfg_wr),
		.cfg_sel(cfg_sel), .cfg_src(cfg_src), .cfg_vec(cfg_vec), .mask_wr(mask_wr),
		.mask_val(mask_val), .cascade_wr(casc_wr), .cascade_val(casc_val), .eoi(eoi),
		.inta(inta), .int_req(int_req), .ack_vector(vec), .ack_vector_oe(vec_oe),
		.in_service(in_svc), .cfg_refused(refused), .cas_addr(cas), .cas_addr_oe(cas_oe));
	bir_slave_card #(.CARD_ID(3'h2), .CARD_VEC(8'h60)) card (.raise(card_raise), .inta(inta),
		.cas_addr(cas), .cas_addr_oe(cas_oe), .request_n(bp1_n), .resp_oe(card_oe),
		.resp_vec(card_vec));

	// Clock and cycle count
	always #10 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic check_count(input string what, input int exp, input int got);
		samples_checked++;
		if (got != exp) begin
			mismatches++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask : check_count

	task automatic write_cfg(input logic [2:0] sel, input bir_src_t src, input bir_vec_t v);
		cfg_sel = sel;
		cfg_src = src;
		cfg_vec = v;
		cfg_wr = 1'b1;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask : write_cfg

	task automatic write_mask(input logic [7:0] m);
		mask_val = m;
		mask_wr = 1'b1;
		@(negedge clk);
		mask_wr = 1'b0;
	endtask : write_mask

	task automatic write_casc(input logic [7:0] m);
		casc_val = m;
		casc_wr = 1'b1;
		@(negedge clk);
		casc_wr = 1'b0;
	endtask : write_casc

	task automatic do_eoi();
		eoi = 1'b1;
		@(negedge clk);
		eoi = 1'b0;
	endtask : do_eoi

	// Bounded wait for a request; a hang ends the run
	task automatic wait_req(output int t);
		int n;
		n = 0;
		while (int_req !== 1'b1 && n < 600) begin
			@(negedge clk);
			n++;
		end
		t = cyc;
		if (n >= 600) begin
			mismatches++;
			$display("ERROR int_req expected 1 seen %b", int_req);
			finish_test();
		end
	endtask : wait_req

	task automatic quiet(input int n, input string what);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(negedge clk);
			seen = seen | int_req;
		end
		check(what, 8'h00, {7'h00, seen});
	endtask : quiet

	// One acknowledge cycle; a cascaded one expects the input index on A8..A10
	task automatic ack(input bir_vec_t v, input logic [7:0] s, input logic casc);
		inta = 1'b1;
		repeat (2) @(negedge clk);
		check("int_req_drop", 8'h00, {7'h00, int_req});
		check("in_service", s, in_svc);
		check("vector_oe", {7'h00, ~casc}, {7'h00, vec_oe});
		if (casc) begin
			check("cas_addr", v, {4'h0, cas_oe, cas});
			check("slave_vector", 8'h60, card_vec);
			check("slave_oe", 8'h01, {7'h00, card_oe});
		end else begin
			check("ack_vector", v, vec);
		end
		inta = 1'b0;
		repeat (3) @(negedge clk);
		check("release", 8'h00, {5'h00, card_oe, vec_oe, cas_oe});
	endtask : ack

	task automatic serve(input bir_vec_t v, input logic [7:0] s);
		ack(v, s, 1'b0);
		do_eoi();
	endtask : serve

	task automatic t_reset();
		check("reset_outputs", 8'h00, {4'h0, int_req, vec_oe, cas_oe, refused});
		check("reset_service", 8'h00, in_svc);
		ack(8'h0F, 8'h00, 1'b0);
	endtask : t_reset

	// Two at once: lowest index first, the other waits for end of service
	task automatic t_priority();
		int t;
		tmr[0] = 1'b1;
		exp_irq = 1'b1;
		wait_req(t);
		tmr[0] = 1'b0;
		exp_irq = 1'b0;
		ack(8'h08, 8'h01, 1'b0);
		quiet(10, "lower_held");
		do_eoi();
		wait_req(t);
		serve(8'h09, 8'h02);
		// Second and third backplane lines on their preset inputs
		bp2_n = 1'b0;
		wait_req(t);
		bp2_n = 1'b1;
		serve(8'h0B, 8'h08);
		bp3_n = 1'b0;
		wait_req(t);
		bp3_n = 1'b1;
		serve(8'h0C, 8'h10);
	endtask : t_priority

	task automatic t_mask();
		int t;
		write_mask(8'h01);
		tmr[0] = 1'b1;
		quiet(12, "masked");
		tmr[0] = 1'b0;
		write_mask(8'h00);
		wait_req(t);
		serve(8'h08, 8'h01);
	endtask : t_mask

	task automatic t_cascade();
		int t;
		write_casc(8'h04);
		card_raise = 1'b1;
		wait_req(t);
		card_raise = 1'b0;
		ack(8'h0A, 8'h04, 1'b1);
		do_eoi();
		write_casc(8'h00);
	endtask : t_cascade

	// Duplicate vector is refused whole, the route included
	task automatic t_reprogram();
		int t;
		logic seen;
		write_cfg(3'h5, SRC_SER0, 8'h08);
		seen = refused;
		@(negedge clk);
		check("refused", 8'h01, {7'h00, seen | refused});
		ser[0] = 1'b1;
		quiet(12, "refused_route");
		ser[0] = 1'b0;
		repeat (6) @(negedge clk);
		write_cfg(3'h5, SRC_SER0, 8'h40);
		check("accepted", 8'h00, {7'h00, refused});
		ser[0] = 1'b1;
		wait_req(t);
		ser[0] = 1'b0;
		serve(8'h40, 8'h20);
	endtask : t_reprogram

	task automatic t_front();
		int t;
		for (int k = 0; k < 3; k++) begin
			write_cfg(3'(k + 3), 4'(k), 8'(8'h0B + k));
			// Let an edge pass so the strobe is not raised again in the same step
			@(negedge clk);
		end
		for (int k = 0; k < 4; k++) begin
			front_n[k] = 1'b0;
			wait_req(t);
			front_n[k] = 1'b1;
			serve(8'(8'h0B + k), 8'(8'h08 << k));
		end
	endtask : t_front

	task automatic t_rtc();
		int t[4];
		write_cfg(3'h7, SRC_RTC, 8'h50);
		wait_req(t[0]);
		serve(8'h50, 8'h80);
		period = PER_SEC;
		for (int i = 0; i < 4; i++) begin
			wait_req(t[i]);
			serve(8'h50, 8'h80);
		end
		check_count("second_period", 64 * 4, t[3] - t[2]);
		period = PER_MIN;
		quiet(300, "minute_quiet");
		period = PER_HOUR;
		quiet(300, "hour_quiet");
	endtask : t_rtc

	// Main sequence
	initial begin
		repeat (8) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		t_reset();
		t_priority();
		t_mask();
		t_cascade();
		t_reprogram();
		t_front();
		t_rtc();
		finish_test();
	end
endmodule : board_interrupt_routing_bench
`default_nettype wire
